// ==== fircb_bank.sv ====
// Notes on behaviour
// - Side-tap registers hold a signed 12-bit coefficient in 11:0, 15:12 reserved, R/W.
// - In dual-channel mode the five registers feed channel A taps three to seven in order.
// - In single-channel mode the same registers feed the merged filter's taps.
// - The fifth-tap coefficient is the centre of a nine-tap filter.
// - The centre register is 24 bits with an 18-bit signed coefficient in 17:0.
// - Readback of any coefficient always returns zero in the coefficient MSB.
// - Every coefficient register resets to zero.
// - Tap four at 0x41E, centre at 0x420, tap six at 0x423, tap seven at 0x425.
// - Filter mode 0 disables and 2 enables the filter; 1 and 3 are reserved.
// - Side weight field 0..6 sets side LSB weight to 2^(field-16), centre excluded.
// - Merge combines both filters into one; software sets it in single-channel mode.
//
// Our own choice: the APB slave port.
module fircb_bank
    import fircb_pkg::*;
(
    // Clock and reset
    input  wire logic                  MCLK,
    input  wire logic                  RESET_N,
    // APB slave
    input  wire logic                  PSEL,
    input  wire logic                  PENABLE,
    input  wire logic                  PWRITE,
    input  wire logic [15:0]           PADDR,
    input  wire logic [31:0]           PWDATA,
    output logic      [31:0]           PRDATA,
    output logic                       PREADY,
    output logic                       PSLVERR,
    // Filter side
    input  wire logic                  LINK_OUTPUT_ENABLE,
    output fircb_pkg::fircb_taps_type  TAPS,
    output fircb_pkg::fircb_route_type ROUTE,
    output logic      [2:0]            SIDE_COEF_WEIGHT
);
    import fircb_pkg::*;

    function automatic logic hit(input logic [15:0] addr, input logic [11:0] idx);
        hit = (addr[1:0] == 2'h0) && (addr[15:2] == {2'h0, idx});
    endfunction : hit

    logic [SIDE_REG_W-1:0]   tap_reg [4];
    logic [CENTER_REG_W-1:0] center_reg;
    logic [7:0]              cfg;
    logic                    link_meta;
    logic                    link_sync;

    wire logic setup     = PSEL && !PENABLE;
    wire logic wr_go     = PSEL && PENABLE && PWRITE && PREADY;
    wire logic hit_tap3  = hit(PADDR, TAP3_IDX);
    wire logic hit_tap4  = hit(PADDR, TAP4_IDX);
    wire logic hit_ctr   = hit(PADDR, CENTER_IDX);
    wire logic hit_tap6  = hit(PADDR, TAP6_IDX);
    wire logic hit_tap7  = hit(PADDR, TAP7_IDX);
    wire logic hit_cfg   = hit(PADDR, CFG_IDX);
    wire logic hit_stat  = hit(PADDR, STATUS_IDX);
    wire logic [3:0] hit_side = {hit_tap7, hit_tap6, hit_tap4, hit_tap3};
    wire logic mapped    = |hit_side || hit_ctr || hit_cfg || hit_stat;
    wire logic [1:0] mode_f  = cfg[CFG_MODE_LSB +: 2];
    wire logic [2:0] scw_f   = cfg[CFG_SCW_LSB +: 3];
    wire logic       merge_f = cfg[CFG_MERGE_BIT];
    wire logic       single_f = cfg[CFG_SINGLE_BIT];

    wire logic [31:0] rd_side [4];
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_rd
            assign rd_side[g] = {16'h0000, tap_reg[g][15:12], 1'b0, tap_reg[g][10:0]};
        end
    endgenerate
    wire logic [31:0] rd_ctr = {8'h00, center_reg[23:18], 1'b0, center_reg[16:0]};

    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h00000000;
        if (hit_tap3) begin
            next_rdata = rd_side[0];
        end else if (hit_tap4) begin
            next_rdata = rd_side[1];
        end else if (hit_ctr) begin
            next_rdata = rd_ctr;
        end else if (hit_tap6) begin
            next_rdata = rd_side[2];
        end else if (hit_tap7) begin
            next_rdata = rd_side[3];
        end else if (hit_cfg) begin
            next_rdata = {24'h000000, cfg};
        end else if (hit_stat) begin
            next_rdata = {28'h0000000, link_sync, ROUTE == ROUTE_MERGED,
                          ROUTE == ROUTE_CHAN_A, ROUTE != ROUTE_NONE};
        end
    end

    // No wait state: answer registered in the setup phase, ready in the first access cycle
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h00000000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= setup;
            PSLVERR <= setup && !mapped;
            PRDATA  <= (setup && !PWRITE) ? next_rdata : 32'h00000000;
        end
    end

    generate
        for (g = 0; g < 4; g++) begin : g_tap
            always_ff @(posedge MCLK) begin
                if (!RESET_N) begin
                    tap_reg[g] <= SIDE_RESET;
                end else if (wr_go && hit_side[g]) begin
                    tap_reg[g] <= PWDATA[SIDE_REG_W-1:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            center_reg <= CENTER_RESET;
            cfg        <= CFG_RESET;
        end else if (wr_go && hit_ctr) begin
            center_reg <= PWDATA[CENTER_REG_W-1:0];
        end else if (wr_go && hit_cfg) begin
            cfg        <= PWDATA[7:0];
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            link_meta <= 1'b0;
            link_sync <= 1'b0;
        end else begin
            link_meta <= LINK_OUTPUT_ENABLE;
            link_sync <= link_meta;
        end
    end

    wire fircb_route_type next_route =
        (mode_f != MODE_ON) ? ROUTE_NONE :
        (merge_f || single_f) ? ROUTE_MERGED : ROUTE_CHAN_A;
    wire logic [2:0] next_scw = (scw_f > 3'(SCW_MAX)) ? 3'(SCW_MAX) : scw_f;

    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            TAPS             <= '0;
            ROUTE            <= ROUTE_NONE;
            SIDE_COEF_WEIGHT <= 3'h0;
        end else begin
            TAPS.tap3        <= tap_reg[0][SIDE_W-1:0];
            TAPS.tap4        <= tap_reg[1][SIDE_W-1:0];
            TAPS.center      <= center_reg[CENTER_W-1:0];
            TAPS.tap6        <= tap_reg[2][SIDE_W-1:0];
            TAPS.tap7        <= tap_reg[3][SIDE_W-1:0];
            ROUTE            <= next_route;
            SIDE_COEF_WEIGHT <= next_scw;
        end
    end

    // Assertions
    // Steps of one register transfer
    sequence s_access;
        PSEL && PENABLE && PREADY;
    endsequence

    sequence s_store(hit_x);
        PSEL && PENABLE && PWRITE && PREADY && hit_x;
    endsequence

    sequence s_wr_ctr;
        PSEL && PENABLE && PWRITE && PREADY && hit_ctr;
    endsequence

    chk_center_write: assert property (@(posedge MCLK) disable iff (!RESET_N)
        s_wr_ctr |=> ##1 (TAPS.center == $past(PWDATA[17:0], 2)))
        else $error("centre tap not loaded");

    chk_center_addr: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (wr_go && PADDR == 16'h1080) |=> ##1 (TAPS.center == $past(PWDATA[17:0], 2)))
        else $error("centre tap address wrong");

    chk_center_hold: assert property (@(posedge MCLK) disable iff (!RESET_N)
        !(wr_go && hit_ctr) |=> $stable(center_reg))
        else $error("centre register changed without write");

    chk_center_follow: assert property (@(posedge MCLK) disable iff (!RESET_N)
        1'b1 |=> (TAPS.center == $past(center_reg[CENTER_W-1:0])))
        else $error("centre tap not driven from centre register");

    chk_tap3_write: assert property (@(posedge MCLK) disable iff (!RESET_N)
        s_store(hit_tap3) |=> ##1 (TAPS.tap3 == $past(PWDATA[11:0], 2)))
        else $error("tap three not loaded");

    chk_tap4_write: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (wr_go && PADDR == 16'h1078) |=> ##1 (TAPS.tap4 == $past(PWDATA[11:0], 2)))
        else $error("tap four address wrong");

    chk_tap6_write: assert property (@(posedge MCLK) disable iff (!RESET_N)
        s_store(hit_tap6) |=> ##1 (TAPS.tap6 == $past(PWDATA[11:0], 2)))
        else $error("tap six not loaded");

    chk_tap7_write: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (wr_go && PADDR == 16'h1094) |=> ##1 (TAPS.tap7 == $past(PWDATA[11:0], 2)))
        else $error("tap seven not loaded");

    chk_side_hold: assert property (@(posedge MCLK) disable iff (!RESET_N)
        !(wr_go && hit_side[0]) |=> $stable(tap_reg[0]))
        else $error("side register changed without write");

    chk_side_follow: assert property (@(posedge MCLK) disable iff (!RESET_N)
        1'b1 |=> (TAPS.tap4 == $past(tap_reg[1][11:0]) && TAPS.tap6 == $past(tap_reg[2][11:0])))
        else $error("side taps out of order");

    chk_read_msb: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (setup && !PWRITE && |hit_side) |=> (PRDATA[11] == 1'b0 && PRDATA[31:16] == 16'h0))
        else $error("side readback MSB not zero");

    chk_ctr_msb: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (setup && !PWRITE && hit_ctr) |=> (PRDATA[17] == 1'b0))
        else $error("centre readback MSB not zero");

    chk_rdata_idle: assert property (@(posedge MCLK) disable iff (!RESET_N)
        !(setup && !PWRITE) |=> (PRDATA == 32'h00000000))
        else $error("read data outside a read");

    chk_reset_zero: assert property (@(posedge MCLK)
        !RESET_N |=> (tap_reg[0] == 16'h0 && center_reg == 24'h0 && tap_reg[3] == 16'h0))
        else $error("coefficient not cleared");

    chk_reset_outputs: assert property (@(posedge MCLK)
        !RESET_N |=> (TAPS == '0 && ROUTE == ROUTE_NONE && SIDE_COEF_WEIGHT == 3'h0))
        else $error("filter outputs not cleared");

    chk_mode_off: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (mode_f != MODE_ON) |=> (ROUTE == ROUTE_NONE))
        else $error("filter enabled in non-enable mode");

    chk_mode_on: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (mode_f == MODE_ON) |=> (ROUTE != ROUTE_NONE))
        else $error("filter not enabled in enable mode");

    chk_merge_route: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (mode_f == MODE_ON && merge_f) |=> (ROUTE == ROUTE_MERGED))
        else $error("merge not routed");

    chk_single_route: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (mode_f == MODE_ON && single_f) |=> (ROUTE == ROUTE_MERGED))
        else $error("single channel not routed to merged filter");

    chk_dual_route: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (mode_f == MODE_ON && !merge_f && !single_f) |=> (ROUTE == ROUTE_CHAN_A))
        else $error("dual route wrong");

    chk_weight_range: assert property (@(posedge MCLK) disable iff (!RESET_N)
        SIDE_COEF_WEIGHT <= 3'h6)
        else $error("weight out of range");

    chk_weight_follow: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (scw_f <= 3'h6) |=> (SIDE_COEF_WEIGHT == $past(scw_f)))
        else $error("weight does not follow field");

    chk_weight_clamp: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (scw_f > 3'h6) |=> (SIDE_COEF_WEIGHT == 3'h6))
        else $error("weight not clamped");

    chk_ready_wait: assert property (@(posedge MCLK) disable iff (!RESET_N)
        setup |=> PREADY)
        else $error("no answer after setup");

    chk_ready_pulse: assert property (@(posedge MCLK) disable iff (!RESET_N)
        s_access |=> !PREADY)
        else $error("ready held past access");

    chk_slverr_unmapped: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (setup && !mapped) |=> (PREADY && PSLVERR))
        else $error("unmapped access not refused");

    chk_slverr_mapped: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (setup && mapped) |=> !PSLVERR)
        else $error("mapped access refused");

    chk_link_sync: assert property (@(posedge MCLK) disable iff (!RESET_N)
        link_sync |-> $past(link_meta))
        else $error("link enable skipped a stage");
endmodule : fircb_bank

// ==== fircb_bank_tb_top.sv ====
module fircb_bank_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import fircb_pkg::*;
    localparam logic [15:0] coef_addr [5] = '{16'h1070, 16'h1078, 16'h1080, 16'h108C, 16'h1094};
    localparam logic [31:0] coef_wr [5] = '{32'hFFFF_FA53, 32'h0000_9B21, 32'hFFFE_1234,
                                            32'h0000_0765, 32'h0000_5800};
    localparam logic [31:0] coef_rd [5] = '{32'h0000_F253, 32'h0000_9321, 32'h00FC_1234,
                                            32'h0000_0765, 32'h0000_5000};
    localparam logic [7:0] cfg_data [8] = '{8'h02, 8'h22, 8'h42, 8'h1A,
                                            8'h1E, 8'h01, 8'h03, 8'h00};
    localparam logic [3:0] cfg_status [8] = '{4'h3, 4'h5, 4'h5, 4'h3, 4'h3, 4'h0, 4'h0, 4'h0};
    localparam fircb_route_type cfg_route [8] = '{ROUTE_CHAN_A, ROUTE_MERGED, ROUTE_MERGED,
        ROUTE_CHAN_A, ROUTE_CHAN_A, ROUTE_NONE, ROUTE_NONE, ROUTE_NONE};
    localparam logic [2:0] cfg_weight [8] = '{3'h0, 3'h0, 3'h0, 3'h6, 3'h6, 3'h0, 3'h0, 3'h0};
    logic            mclk = 1'b0;
    logic            reset_n = 1'b0;
    logic            psel = 1'b0;
    logic            penable = 1'b0;
    logic            pwrite = 1'b0;
    logic [15:0]     paddr = 16'h0000;
    logic [31:0]     pwdata = 32'h0000_0000;
    logic            link_output_enable = 1'b0;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    fircb_taps_type  taps;
    fircb_route_type route;
    logic [2:0]      side_coef_weight;
    logic [31:0]     rd;
    logic            err;
    int              err_total = 0;
    int              n_compared = 0;

    always #50 mclk = ~mclk;

    fircb_bank fircb_bank_inst (
        .MCLK(mclk), .RESET_N(reset_n),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .LINK_OUTPUT_ENABLE(link_output_enable), .TAPS(taps), .ROUTE(route),
        .SIDE_COEF_WEIGHT(side_coef_weight)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: seen %08h expected %08h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    // Request held until pready is sampled high; bounded wait
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            err_total++;
            print_verdict();
        end
    endtask : apb

    initial begin
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        check(taps[31:0], 32'h0); // taps cleared
        check(taps[63:32], 32'h0); // taps cleared
        check({30'h0, taps[65:64]}, 32'h0); // taps cleared
        check({30'h0, route}, {30'h0, ROUTE_NONE}); // filter off after reset
        check({29'h0, side_coef_weight}, 32'h0); // weight cleared
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, coef_addr[i], 32'h0);
            check(rd, 32'h0); // register cleared
            check({31'h0, err}, 32'h0); // mapped read accepted
        end
        for (int i = 0; i < 5; i++) apb(1'b1, coef_addr[i], coef_wr[i]);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, coef_addr[i], 32'h0);
            check(rd, coef_rd[i]); // masked readback
        end
        repeat (2) @(posedge mclk);
        check({20'h0, taps.tap3}, 32'hA53); // third tap
        check({20'h0, taps.tap4}, 32'hB21); // fourth tap
        check({14'h0, taps.center}, 32'h21234); // centre tap
        check({20'h0, taps.tap6}, 32'h765); // sixth tap
        check({20'h0, taps.tap7}, 32'h800); // seventh tap
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, 16'h1040, {24'h0, cfg_data[i]});
            repeat (2) @(posedge mclk);
            check({30'h0, route}, {30'h0, cfg_route[i]}); // route
            check({29'h0, side_coef_weight}, {29'h0, cfg_weight[i]}); // weight clamp
            apb(1'b0, 16'h1040, 32'h0);
            check(rd, {24'h0, cfg_data[i]}); // config readback
            apb(1'b0, 16'h1044, 32'h0);
            check(rd, {28'h0, cfg_status[i]}); // status bits
        end
        apb(1'b1, 16'h1048, 32'h1234_5678);
        check({31'h0, err}, 32'h1); // unmapped write
        apb(1'b1, 16'h1071, 32'h0);
        check({31'h0, err}, 32'h1); // misaligned write
        apb(1'b0, 16'h1070, 32'h0);
        check(rd, 32'h0000_F253); // tap3 untouched
        apb(1'b0, 16'h104C, 32'h0);
        check({rd[30:0], err}, 32'h1); // unmapped read
        link_output_enable <= 1'b1;
        repeat (4) @(posedge mclk);
        apb(1'b0, 16'h1044, 32'h0);
        check(rd, 32'h8); // link enable visible
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        check(taps[31:0], 32'h0); // taps cleared again
        check(taps[63:32], 32'h0); // taps cleared again
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, coef_addr[i], 32'h0);
            check(rd, 32'h0); // register cleared again
        end
        print_verdict();
    end
endmodule : fircb_bank_tb_top

// ==== fircb_pkg.sv ====
package fircb_pkg;
    // Printed offsets are not all multiples of four: they are indices
    localparam logic [11:0] TAP3_IDX    = 12'h41C;
    localparam logic [11:0] TAP4_IDX    = 12'h41E;
    localparam logic [11:0] CENTER_IDX  = 12'h420;
    localparam logic [11:0] TAP6_IDX    = 12'h423;
    localparam logic [11:0] TAP7_IDX    = 12'h425;
    localparam logic [11:0] CFG_IDX     = 12'h410;
    localparam logic [11:0] STATUS_IDX  = 12'h411;
    localparam int          SIDE_W      = 12;
    localparam int          CENTER_W    = 18;
    localparam int          SIDE_REG_W  = 16;
    localparam int          CENTER_REG_W = 24;
    localparam int          SCW_MAX     = 6;
    localparam logic [SIDE_REG_W-1:0]   SIDE_RESET   = 16'h0000;
    localparam logic [CENTER_REG_W-1:0] CENTER_RESET = 24'h000000;
    localparam logic [1:0]  MODE_OFF    = 2'h0;
    localparam logic [1:0]  MODE_ON     = 2'h2;
    // Config register fields
    localparam int          CFG_MODE_LSB  = 0;
    localparam int          CFG_SCW_LSB   = 2;
    localparam int          CFG_MERGE_BIT = 5;
    localparam int          CFG_SINGLE_BIT = 6;
    localparam logic [7:0]  CFG_RESET     = 8'h00;

    typedef struct packed {
        logic [SIDE_W-1:0]   tap3;
        logic [SIDE_W-1:0]   tap4;
        logic [CENTER_W-1:0] center;
        logic [SIDE_W-1:0]   tap6;
        logic [SIDE_W-1:0]   tap7;
    } fircb_taps_type;

    typedef enum logic [1:0] {
        ROUTE_NONE,
        ROUTE_CHAN_A,
        ROUTE_MERGED
    } fircb_route_type;
endpackage : fircb_pkg
